// File: hw/ccru_map.vh
// Purpose: constants of the core clock and reset unit
// Assumes: core_clk is the oscillator, 100 MHz in simulation
// Notes:   rate codes, divider counts and state numbering
`ifndef CCRU_MAP_VH
`define CCRU_MAP_VH
`define CCRU_CODE_LS6        3'h1
`define CCRU_CODE_LS12       3'h4
`define CCRU_CODE_FS         3'h6
`define CCRU_OSC_PER_STATE_N 3'h2
`define CCRU_OSC_PER_STATE_F 3'h1
`define CCRU_OSC_PER_STATE_L 3'h4
`define CCRU_STATES_PER_PCYC 3'h6
`define CCRU_STATE_PCA       3'h5
`define CCRU_STATE_FIRST     3'h1
`define CCRU_CNT_ZERO        3'h0
`define CCRU_CNT_ONE         3'h1
`define CCRU_SAMPLE_DIV_LS   4'h8
`define CCRU_SAMPLE_DIV_FS   4'h1
`define CCRU_SAMPLE_ZERO     4'h0
`define CCRU_SAMPLE_ONE      4'h1
`define CCRU_RESET_VECTOR    24'hff0000
`define CCRU_RST_STRETCH     4'h8
`endif

// File: hw/ccru_tick_div.v
// Purpose: divide-by-n tick generator, one pulse every n core_clk cycles
// Assumes: n is stable between restarts; n of one ticks every cycle
// Notes:   restart forces the count back so a tick follows n cycles later
`timescale 1ns/10ps
`include "ccru_map.vh"
module ccru_tick_div (
  core_clk,
  resetn,
  restart,
  div_n,
  tick
);
  input        core_clk;
  input        resetn;
  input        restart;
  input  [3:0] div_n;
  output       tick;

  reg    [3:0] cnt_ff;
  wire         wrap;

  assign wrap = (cnt_ff == div_n - `CCRU_SAMPLE_ONE);
  assign tick = wrap;

  always @(posedge core_clk) begin
    if (!resetn || restart) begin
      cnt_ff <= `CCRU_SAMPLE_ZERO;
    end else if (wrap) begin
      cnt_ff <= `CCRU_SAMPLE_ZERO;
    end else begin
      cnt_ff <= cnt_ff + `CCRU_SAMPLE_ONE;
    end
  end
endmodule

// File: hw/ccru_core.v
// Purpose: core clock and reset unit: state/phase timing, peripheral cycle,
//          low-clock mode, usb sample strobe and chip reset combining
// Assumes: core_clk is the oscillator; rate pins are board straps
// Notes:   internal clock is produced as a one-cycle enable per clock period
`timescale 1ns/10ps
`include "ccru_map.vh"
module ccru_core (
  core_clk,
  resetn,
  rate_select_pins,
  hub_variant,
  low_clock_bit,
  usb_reset_req,
  usb_reset_blocks_chip,
  watchdog_expired,
  clk_en_ff,
  phase1_ff,
  phase2_ff,
  state_num_ff,
  state5_phase2_ff,
  pca_tick_ff,
  pll_on_ff,
  full_speed_ff,
  div2_used_ff,
  low_clock_active_ff,
  usb_sample_ff,
  chip_reset_ff,
  reset_vector_ff
);
  input         core_clk;
  input         resetn;
  input  [2:0]  rate_select_pins;
  input         hub_variant;
  input         low_clock_bit;
  input         usb_reset_req;
  input         usb_reset_blocks_chip;
  input         watchdog_expired;
  output        clk_en_ff;
  output        phase1_ff;
  output        phase2_ff;
  output [2:0]  state_num_ff;
  output        state5_phase2_ff;
  output        pca_tick_ff;
  output        pll_on_ff;
  output        full_speed_ff;
  output        div2_used_ff;
  output        low_clock_active_ff;
  output        usb_sample_ff;
  output        chip_reset_ff;
  output [23:0] reset_vector_ff;

  reg           clk_en_ff;
  reg           phase1_ff;
  reg           phase2_ff;
  reg    [2:0]  state_num_ff;
  reg           state5_phase2_ff;
  reg           pca_tick_ff;
  reg           pll_on_ff;
  reg           full_speed_ff;
  reg           div2_used_ff;
  reg           low_clock_active_ff;
  reg           usb_sample_ff;
  reg           chip_reset_ff;
  reg    [23:0] reset_vector_ff;

  reg    [2:0]  osc_cnt_ff;
  reg    [3:0]  rst_cnt_ff;
  reg    [2:0]  per_state;
  reg    [3:0]  sample_div;
  reg           nxt_full;
  reg           code_full;
  wire          one_period;
  wire          pca_point;
  wire          usb_rst_eff;
  wire          rst_src;
  wire          state_end;
  wire          half_pt;
  wire          sample_tick;

  // hub part has no separate usb reset option
  assign usb_rst_eff = usb_reset_req & (hub_variant | ~usb_reset_blocks_chip);
  assign rst_src     = ~resetn | usb_rst_eff | watchdog_expired;

  // rate decode; hub part forced to full speed
  always @* begin
    case (rate_select_pins)
      `CCRU_CODE_FS: begin
        code_full = 1'b1;
      end
      `CCRU_CODE_LS6: begin
        code_full = 1'b0;
      end
      `CCRU_CODE_LS12: begin
        code_full = 1'b0;
      end
      default: begin
        // undefined straps fall back to low speed
        code_full = 1'b0;
      end
    endcase
    nxt_full = hub_variant | code_full;
    // sample rate follows the latched speed, so a strap change mid-run is ignored
    if (full_speed_ff) begin
      sample_div = `CCRU_SAMPLE_DIV_FS;
    end else begin
      sample_div = `CCRU_SAMPLE_DIV_LS;
    end
    if (low_clock_active_ff) begin
      per_state = `CCRU_OSC_PER_STATE_L;
    end else if (full_speed_ff) begin
      per_state = `CCRU_OSC_PER_STATE_F;
    end else begin
      per_state = `CCRU_OSC_PER_STATE_N;
    end
  end

  assign state_end = (osc_cnt_ff == per_state - `CCRU_CNT_ONE);
  // phase 2 starts at the midpoint; a one-period state has phase 2 for its whole cycle
  assign half_pt   = (osc_cnt_ff >= (per_state >> 1));
  // a one-period state carries both phases in its single cycle
  assign one_period = (per_state == `CCRU_OSC_PER_STATE_F);
  // counter array point: last oscillator period of state five
  assign pca_point  = (state_num_ff == `CCRU_STATE_PCA) & state_end;

  // chip reset stretched so every unit sees a full reset
  always @(posedge core_clk) begin
    if (rst_src) begin
      rst_cnt_ff    <= `CCRU_RST_STRETCH;
      chip_reset_ff <= 1'b1;
    end else if (rst_cnt_ff != `CCRU_SAMPLE_ZERO) begin
      rst_cnt_ff    <= rst_cnt_ff - `CCRU_SAMPLE_ONE;
      chip_reset_ff <= 1'b1;
    end else begin
      rst_cnt_ff    <= rst_cnt_ff;
      chip_reset_ff <= 1'b0;
    end
  end

  // rate outputs are latched only while chip reset holds the straps steady
  always @(posedge core_clk) begin
    if (chip_reset_ff) begin
      reset_vector_ff     <= `CCRU_RESET_VECTOR;
      low_clock_active_ff <= 1'b1;
      full_speed_ff       <= nxt_full;
      pll_on_ff           <= nxt_full;
      div2_used_ff        <= ~nxt_full;
      osc_cnt_ff          <= `CCRU_CNT_ZERO;
      state_num_ff        <= `CCRU_STATE_FIRST;
    end else begin
      reset_vector_ff     <= reset_vector_ff;
      full_speed_ff       <= full_speed_ff;
      pll_on_ff           <= pll_on_ff;
      div2_used_ff        <= div2_used_ff;
      if (state_end) begin
        osc_cnt_ff          <= `CCRU_CNT_ZERO;
        low_clock_active_ff <= low_clock_bit;
        if (state_num_ff == `CCRU_STATES_PER_PCYC) begin
          state_num_ff <= `CCRU_STATE_FIRST;
        end else begin
          state_num_ff <= state_num_ff + `CCRU_CNT_ONE;
        end
      end else begin
        osc_cnt_ff          <= osc_cnt_ff + `CCRU_CNT_ONE;
        low_clock_active_ff <= low_clock_active_ff;
        state_num_ff        <= state_num_ff;
      end
    end
  end

  always @(posedge core_clk) begin
    if (chip_reset_ff) begin
      clk_en_ff        <= 1'b0;
      phase1_ff        <= 1'b0;
      phase2_ff        <= 1'b0;
      state5_phase2_ff <= 1'b0;
      pca_tick_ff      <= 1'b0;
    end else begin
      // one internal clock enable per state: /2 low speed, /1 full, /4 low-clock
      clk_en_ff        <= state_end;
      phase1_ff        <= ~half_pt | one_period;
      phase2_ff        <= half_pt;
      state5_phase2_ff <= pca_point;
      pca_tick_ff      <= pca_point;
    end
  end

  // usb sampling strobe independent of low-clock mode
  ccru_tick_div u_sample_div (
    .core_clk (core_clk),
    .resetn   (resetn),
    .restart  (chip_reset_ff),
    .div_n    (sample_div),
    .tick     (sample_tick)
  );

  always @(posedge core_clk) begin
    if (!resetn) begin
      usb_sample_ff <= 1'b0;
    end else begin
      usb_sample_ff <= sample_tick & ~chip_reset_ff;
    end
  end
endmodule

// File: test/ccru_chk.sv
// Purpose: port checker for ccru_core
// Assumes: straps and hub_variant change only around a chip reset
// Notes:   timing checks are off while chip_reset_ff is high
`timescale 1ns/10ps
module ccru_chk (
  input wire logic        core_clk, resetn, hub_variant, usb_reset_req,
  input wire logic        usb_reset_blocks_chip, watchdog_expired, state5_phase2_ff,
  input wire logic        pca_tick_ff, pll_on_ff, full_speed_ff, div2_used_ff,
  input wire logic        low_clock_active_ff, usb_sample_ff, chip_reset_ff,
  input wire logic [2:0]  state_num_ff,
  input wire logic [23:0] reset_vector_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn || chip_reset_ff);
  AST_STATE_SEQ: assert property ($changed(state_num_ff) && !$past(chip_reset_ff) |->
    state_num_ff == ($past(state_num_ff) % 3'h6) + 3'h1) else $error("state order");
  AST_PCA_PAIR: assert property (pca_tick_ff == state5_phase2_ff) else $error("pca pair");
  AST_PCA_S5: assert property (pca_tick_ff |-> $past(state_num_ff) == 3'h5)
    else $error("pca not after state 5");
  AST_LS_DECODE: assert property (!full_speed_ff |-> div2_used_ff && !pll_on_ff)
    else $error("low speed decode");
  AST_FS_DECODE: assert property (full_speed_ff |-> !div2_used_ff && pll_on_ff)
    else $error("full speed decode");
  AST_LS_SAMPLE: assert property (usb_sample_ff && !full_speed_ff |=>
    !usb_sample_ff [*7] ##1 usb_sample_ff) else $error("low speed sample spacing");
  AST_RST_SRC: assert property (disable iff (1'b0) !resetn || watchdog_expired ||
    usb_reset_req && (hub_variant || !usb_reset_blocks_chip) |=> chip_reset_ff)
    else $error("reset source ignored");
  AST_LC_RESET: assert property (disable iff (1'b0) $fell(chip_reset_ff) |->
    low_clock_active_ff) else $error("no low clock after reset");
  AST_VECTOR: assert property (reset_vector_ff == 24'hff0000) else $error("vector");
  AST_HUB_FS: assert property (hub_variant |-> full_speed_ff) else $error("hub slow");
  cover property (pca_tick_ff);
  cover property ($fell(low_clock_active_ff));
  cover property (usb_reset_req && usb_reset_blocks_chip && !hub_variant);
endmodule
bind ccru_core ccru_chk u_chk (.core_clk, .resetn, .hub_variant, .usb_reset_req,
  .usb_reset_blocks_chip, .watchdog_expired, .state5_phase2_ff, .pca_tick_ff, .pll_on_ff,
  .full_speed_ff, .div2_used_ff, .low_clock_active_ff, .usb_sample_ff, .chip_reset_ff,
  .state_num_ff, .reset_vector_ff);

// File: test/ccru_board.sv
// Purpose: board strap model for the rate select pins
// Assumes: pick chooses one of the three legal straps
// Notes:   no other code is ever driven
`timescale 1ns/10ps
module ccru_board (
  input  wire logic [1:0] pick,
  output logic      [2:0] rate_select_pins
);
  assign rate_select_pins = (pick == 2'h0) ? 3'h1 : (pick == 2'h1) ? 3'h4 : 3'h6;
endmodule

// File: test/ccru_core_tb_top.sv
// Purpose: self-checking bench for ccru_core
// Assumes: board model straps legal codes only
// Notes:   model gives state length from strap and low-clock bit
`timescale 1ns/10ps
module ccru_core_tb_top;
  logic core_clk = 0, resetn = 0, hub_variant = 0, low_clock_bit = 1, usb_reset_req = 0;
  logic usb_reset_blocks_chip = 0, watchdog_expired = 0;
  logic [1:0] pick = 2'h0;
  wire [2:0] rate_select_pins, state_num_ff;
  wire [23:0] reset_vector_ff;
  wire clk_en_ff, phase1_ff, phase2_ff, state5_phase2_ff, pca_tick_ff, pll_on_ff;
  wire full_speed_ff, div2_used_ff, low_clock_active_ff, usb_sample_ff, chip_reset_ff;
  int err_count = 0, tests_run = 0, seed = 80537, n, m, ce, p1, p2;
  int codes[$] = '{0, 1, 2};
  initial forever #5 core_clk = ~core_clk;
  ccru_board brd (.pick, .rate_select_pins);
  ccru_core dut (.core_clk, .resetn, .rate_select_pins, .hub_variant, .low_clock_bit,
    .usb_reset_req, .usb_reset_blocks_chip, .watchdog_expired, .clk_en_ff, .phase1_ff,
    .phase2_ff, .state_num_ff, .state5_phase2_ff, .pca_tick_ff, .pll_on_ff, .full_speed_ff,
    .div2_used_ff, .low_clock_active_ff, .usb_sample_ff, .chip_reset_ff, .reset_vector_ff);
  function int elen(int c, bit lc);
    return lc ? 4 : (c == 2 ? 1 : 2);
  endfunction
  task give_verdict;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(string nm, int e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  task hang;
    err_count++;
    give_verdict;
  endtask
  task st_len(output int k);
    logic [2:0] s;
    s = state_num_ff;
    k = 0;
    do begin @(posedge core_clk); #1; k++; end while (state_num_ff === s && k < 40);
    if (k >= 40) hang;
  endtask
  task rst_done;
    n = 0;
    while (chip_reset_ff !== 0 && n < 20) begin @(posedge core_clk); #1; n++; end
    if (n >= 20) hang;
  endtask
  task do_rst;
    @(posedge core_clk); resetn <= 0;
    repeat (8) @(posedge core_clk);
    resetn <= 1;
    #1; rst_done;
    chk("stretch", 1, n >= 8);
    chk("lc_active", 1, low_clock_active_ff);
    chk("vector", 'hff0000, reset_vector_ff);
  endtask
  initial begin
    foreach (codes[i]) begin
      @(posedge core_clk);
      pick <= codes[i][1:0];
      low_clock_bit <= 1;
      do_rst;
      chk("full_speed", codes[i] == 2, full_speed_ff);
      m = 0;
      repeat (8) begin @(posedge core_clk); #1; m += (usb_sample_ff === 1); end
      chk("samples", codes[i] == 2 ? 8 : 1, m);
      st_len(n); st_len(n);
      chk("lc_len", elen(codes[i], 1), n);
      ce = 0;
      repeat (8) begin
        @(posedge core_clk);
        #1;
        ce += (clk_en_ff === 1);
      end
      chk("lc_clk_en", 8 / elen(codes[i], 1), ce);
      @(posedge core_clk); low_clock_bit <= 0;
      repeat (3) st_len(n);
      chk("st_len", elen(codes[i], 0), n);
      m = 0;
      while (pca_tick_ff !== 1 && m < 60) begin @(posedge core_clk); #1; m++; end
      if (m >= 60) hang;
      m = 0;
      do begin @(posedge core_clk); #1; m++; end while (pca_tick_ff !== 1 && m < 60);
      chk("pca_period", 6 * elen(codes[i], 0), m);
      chk("pll_on", codes[i] == 2, pll_on_ff);
      chk("div2_used", codes[i] != 2, div2_used_ff);
      ce = 0;
      p1 = 0;
      p2 = 0;
      repeat (12) begin
        @(posedge core_clk);
        #1;
        ce += (clk_en_ff === 1);
        p1 += (phase1_ff === 1);
        p2 += (phase2_ff === 1);
      end
      chk("clk_en", 12 / elen(codes[i], 0), ce);
      chk("phase1", elen(codes[i], 0) == 1 ? 12 : 6, p1);
      chk("phase2", elen(codes[i], 0) == 1 ? 12 : 6, p2);
    end
    @(posedge core_clk); watchdog_expired <= 1;
    repeat (2 + ($random(seed) & 3)) @(posedge core_clk);
    watchdog_expired <= 0;
    #1; chk("wdog", 1, chip_reset_ff);
    rst_done;
    @(posedge core_clk); usb_reset_blocks_chip <= 1; usb_reset_req <= 1;
    repeat (3) @(posedge core_clk);
    #1; chk("usb_blocked", 0, chip_reset_ff);
    @(posedge core_clk); hub_variant <= 1;
    repeat (2) @(posedge core_clk);
    #1; chk("usb_hub", 1, chip_reset_ff);
    @(posedge core_clk); usb_reset_req <= 0; pick <= 2'h0;
    do_rst;
    chk("hub_fs", 1, full_speed_ff);
    give_verdict;
  end
endmodule
